// ### iwrs_pkg.sv
// Purpose: Shared constants and types for the serial wiper register slave
// Assumes: Core clock period of 100 ns
// Notes:   Settle counts are derived from the printed times
package iwrs_pkg;

   // Wiper register
   localparam int             WIPER_W        = 7;
   localparam logic [7:0]     WIPER_ADDR     = 8'h00;
   localparam logic [6:0]     WIPER_RESET    = 7'h40;

   // Bit position of the direction bit in the address byte
   localparam int             RW_BIT         = 0;
   localparam logic [2:0]     LAST_BIT       = 3'h7;

   // Timing
   localparam int             CORE_PERIOD_NS = 100;
   localparam int             SETTLE_MIN_NS  = 5000;
   localparam int             SETTLE_MAX_NS  = 10000;
   localparam int             POWERUP_MAX_NS = 1000000;
   localparam logic [7:0]     SETTLE_CYC     = 8'((SETTLE_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
   localparam int             SETTLE_MAX_CYC = SETTLE_MAX_NS / CORE_PERIOD_NS;

   // Link-side protocol states
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ADDR,
      ST_REG,
      ST_DATA,
      ST_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_WAIT
   } iwrs_state_t;

endpackage : iwrs_pkg

// ### iwrs_sync.sv
// Purpose: Two-stage synchroniser for levels entering a clock domain
// Assumes: Inputs are levels or toggles, never one-cycle pulses
// Notes:   Not gated by the clock enable, so a frozen domain still sees fresh levels
`timescale 1ns/1ps
module iwrs_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : iwrs_sync

// ### iwrs_settle.sv
// Purpose: Moves the wiper tap a fixed settle time after a request
// Assumes: Request data is stable on the cycle of start
// Notes:   A new start during a settle restarts the wait with the new data
`timescale 1ns/1ps
module iwrs_settle (
   // Clock, reset, enable
   input  wire logic                          clk,
   input  wire logic                          rstn,
   input  wire logic                          ce,
   // Request
   input  wire logic                          start,
   input  wire logic [iwrs_pkg::WIPER_W-1:0]  data_in,
   // Tap
   output logic      [iwrs_pkg::WIPER_W-1:0]  tap,
   output logic                               ready,
   output logic                               done
);

   localparam int CHK_LO  = int'(iwrs_pkg::SETTLE_CYC) - 1;
   localparam int CHK_HI  = iwrs_pkg::SETTLE_MAX_CYC - 1;
   localparam int CHK_MAX = iwrs_pkg::SETTLE_MAX_CYC;

   logic [7:0]                      cnt_reg;
   logic                            run_reg;
   logic [iwrs_pkg::WIPER_W-1:0]    hold_reg;
   logic                            fire;

   assign fire = ce && run_reg && (cnt_reg == 8'h00) && !start;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg  <= 8'h00;
         run_reg  <= 1'b0;
         hold_reg <= iwrs_pkg::WIPER_RESET;
      end
      else if (ce)
      begin
         if (start)
         begin
            hold_reg <= data_in;
            cnt_reg  <= iwrs_pkg::SETTLE_CYC - 8'h01;
            run_reg  <= 1'b1;
         end
         else if (run_reg)
         begin
            if (cnt_reg == 8'h00)
               run_reg <= 1'b0;
            else
               cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end

   // Tap output only moves once the wait is over
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tap   <= iwrs_pkg::WIPER_RESET;
         ready <= 1'b0;
         done  <= 1'b0;
      end
      else if (ce)
      begin
         done <= fire;
         if (fire)
         begin
            tap   <= hold_reg;
            ready <= 1'b1;
         end
      end
   end

   chk_settle_window: assert property (
      @(posedge clk) disable iff (!rstn || !ce)
      start |=> (!start throughout (##[CHK_LO:CHK_HI] fire)) or (##[0:CHK_MAX] start))
      else $error("settle time out of window");

   chk_tap_steady: assert property (
      @(posedge clk) disable iff (!rstn)
      !fire |=> $stable(tap))
      else $error("tap moved without a settle");

endmodule : iwrs_settle

// ### iwrs_top.sv
// Purpose: Serial two-wire slave holding a 7-bit wiper register
// Assumes: link_clk oversamples scl and sda at many times the bit rate
// Notes:   The register lives on link_clk; the tap moves on core_clk
`timescale 1ns/1ps

// Behaviour
// - Wiper settles 5 to 10 us after write
// - Wiper takes initial tap 5-10 us after power
// - SDA change while SCL high is start/stop
// - Master clocks; device never drives SCL
// - Start is SDA fall, SCL high; ignore before
// - Stop is SDA rise while SCL high
// - Receiver pulls SDA low on ninth clock
// - Acknowledge own address and written bytes; an index other than 00h and the bytes after it get no ack
// - Read: send byte, continue on ack, else wait
// - Respond only to matching seven-bit identifier
// - Direction bit: one reads, zero writes
// - Seven-bit wiper register, resets to 40h
// - Write drops top bit; read returns zero
// - Third write byte loads wiper register
// - Read: index write, restart, address read
module iwrs_top #(
   parameter logic [6:0] DEV_ID = 7'h2a // Arbitrary identifier value
) (
   // Core clock, reset, enable
   input  wire logic                          core_clk,
   input  wire logic                          rstn,
   input  wire logic                          ce,
   // Link clock
   input  wire logic                          link_clk,
   // Serial pins
   input  wire logic                          scl,
   input  wire logic                          sda_in,
   output logic                               sda_out,
   output logic                               sda_oe,
   // Wiper tap
   output logic      [iwrs_pkg::WIPER_W-1:0]  wiper_tap,
   output logic                               wiper_ready,
   output logic                               wiper_moved
);

   // Link side
   logic [1:0]                      pins_s;
   logic                            ce_s;
   logic                            scl_s;
   logic                            sda_s;
   logic                            scl_d_reg;
   logic                            sda_d_reg;
   iwrs_pkg::iwrs_state_t           state_reg;
   iwrs_pkg::iwrs_state_t           after_reg;
   logic [2:0]                      cnt_reg;
   logic [7:0]                      shift_reg;
   logic [7:0]                      tx_reg;
   logic                            ack_on_reg;
   logic                            oe_reg;
   logic [iwrs_pkg::WIPER_W-1:0]    wiper_position_reg;
   logic                            upd_tgl_reg;

   logic                            start_ev;
   logic                            stop_ev;
   logic                            rise;
   logic                            fall;
   logic                            rx_state;
   logic [7:0]                      byte_in;
   logic                            byte_end;
   logic                            addr_hit;
   logic                            ack_exit;
   logic                            wr_ev;
   logic [7:0]                      tx_byte;

   // Core side
   logic                            tgl_s;
   logic                            tgl_d_reg;
   logic                            init_reg;
   logic                            settle_start;
   logic [iwrs_pkg::WIPER_W-1:0]    settle_data;

   function automatic logic [7:0] read_byte(input logic [iwrs_pkg::WIPER_W-1:0] w);
      read_byte = {1'b0, w};
   endfunction : read_byte

   iwrs_sync #(
      .W (2)
   ) u_pin_sync (
      .clk  (link_clk),
      .rstn (rstn),
      .d    ({scl, sda_in}),
      .q    (pins_s)
   );

   iwrs_sync #(
      .W (1)
   ) u_ce_sync (
      .clk  (link_clk),
      .rstn (rstn),
      .d    (ce),
      .q    (ce_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else if (ce_s)
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // Any SDA edge while SCL stays high is framing, never data
   assign start_ev = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_ev  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   assign rise     = scl_s && !scl_d_reg;
   assign fall     = !scl_s && scl_d_reg;

   assign rx_state = (state_reg == iwrs_pkg::ST_ADDR) || (state_reg == iwrs_pkg::ST_REG) ||
                     (state_reg == iwrs_pkg::ST_DATA);
   assign byte_in  = {shift_reg[6:0], sda_s};
   assign byte_end = rise && (cnt_reg == iwrs_pkg::LAST_BIT);
   assign addr_hit = (byte_in[7:1] == DEV_ID);
   assign ack_exit = (state_reg == iwrs_pkg::ST_ACK) && fall && ack_on_reg;
   assign wr_ev    = ce_s && !start_ev && !stop_ev && (state_reg == iwrs_pkg::ST_DATA) && byte_end;
   assign tx_byte  = read_byte(wiper_position_reg);

   // Protocol sequencing
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= iwrs_pkg::ST_IDLE;
         after_reg <= iwrs_pkg::ST_IDLE;
      end
      else if (ce_s)
      begin
         if (start_ev)
            state_reg <= iwrs_pkg::ST_ADDR;
         else if (stop_ev)
            state_reg <= iwrs_pkg::ST_IDLE;
         else
         begin
            case (state_reg)
               iwrs_pkg::ST_ADDR:
               begin
                  if (byte_end)
                  begin
                     if (addr_hit)
                     begin
                        state_reg <= iwrs_pkg::ST_ACK;
                        after_reg <= byte_in[iwrs_pkg::RW_BIT] ? iwrs_pkg::ST_TX : iwrs_pkg::ST_REG;
                     end
                     else
                        state_reg <= iwrs_pkg::ST_IDLE;
                  end
               end
               iwrs_pkg::ST_REG:
               begin
                  if (byte_end)
                  begin
                     if (byte_in == iwrs_pkg::WIPER_ADDR)
                     begin
                        state_reg <= iwrs_pkg::ST_ACK;
                        after_reg <= iwrs_pkg::ST_DATA;
                     end
                     else
                        state_reg <= iwrs_pkg::ST_WAIT;
                  end
               end
               iwrs_pkg::ST_DATA:
               begin
                  if (byte_end)
                  begin
                     state_reg <= iwrs_pkg::ST_ACK;
                     after_reg <= iwrs_pkg::ST_DATA;
                  end
               end
               iwrs_pkg::ST_ACK:
               begin
                  if (ack_exit)
                     state_reg <= after_reg;
               end
               iwrs_pkg::ST_TX:
               begin
                  if (byte_end)
                     state_reg <= iwrs_pkg::ST_TX_ACK;
               end
               iwrs_pkg::ST_TX_ACK:
               begin
                  if (rise)
                     state_reg <= sda_s ? iwrs_pkg::ST_WAIT : iwrs_pkg::ST_TX;
               end
               iwrs_pkg::ST_IDLE,
               iwrs_pkg::ST_WAIT:
                  state_reg <= state_reg;
               default:
                  state_reg <= iwrs_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Bit counter and receive shifter, sampled on SCL rise
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg   <= 3'h0;
         shift_reg <= 8'h00;
      end
      else if (ce_s)
      begin
         if (start_ev || stop_ev || ack_exit || ((state_reg == iwrs_pkg::ST_TX_ACK) && rise))
            cnt_reg <= 3'h0;
         else if (rise && (rx_state || (state_reg == iwrs_pkg::ST_TX)))
            cnt_reg <= cnt_reg + 3'h1;
         if (rise && rx_state)
            shift_reg <= byte_in;
      end
   end

   // SDA drive: acknowledge and read data change only on SCL fall
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         oe_reg     <= 1'b0;
         ack_on_reg <= 1'b0;
         tx_reg     <= 8'h00;
      end
      else if (ce_s)
      begin
         if (start_ev || stop_ev)
         begin
            oe_reg     <= 1'b0;
            ack_on_reg <= 1'b0;
         end
         else
         begin
            case (state_reg)
               iwrs_pkg::ST_ACK:
               begin
                  if (fall && !ack_on_reg)
                  begin
                     oe_reg     <= 1'b1;
                     ack_on_reg <= 1'b1;
                  end
                  else if (ack_exit)
                  begin
                     ack_on_reg <= 1'b0;
                     if (after_reg == iwrs_pkg::ST_TX)
                     begin
                        oe_reg <= !tx_byte[7];
                        tx_reg <= {tx_byte[6:0], 1'b0};
                     end
                     else
                        oe_reg <= 1'b0;
                  end
               end
               iwrs_pkg::ST_TX:
               begin
                  if (fall)
                  begin
                     oe_reg <= !tx_reg[7];
                     tx_reg <= {tx_reg[6:0], 1'b0};
                  end
               end
               iwrs_pkg::ST_TX_ACK:
               begin
                  if (fall)
                     oe_reg <= 1'b0;
                  if (rise && !sda_s)
                     tx_reg <= tx_byte;
               end
               default:
                  oe_reg <= 1'b0;
            endcase
         end
      end
   end

   // Open-drain: the pin is only ever pulled low, SCL is never driven
   assign sda_out = 1'b0;
   assign sda_oe  = oe_reg;

   // Wiper register, volatile, midscale after reset
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
         wiper_position_reg <= iwrs_pkg::WIPER_RESET;
      else if (wr_ev)
         wiper_position_reg <= byte_in[iwrs_pkg::WIPER_W-1:0];
   end

   // Write event crosses as a toggle; the register stays stable for many link cycles after it
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
         upd_tgl_reg <= 1'b0;
      else if (wr_ev)
         upd_tgl_reg <= !upd_tgl_reg;
   end

   // Core side
   iwrs_sync #(
      .W (1)
   ) u_tgl_sync (
      .clk  (core_clk),
      .rstn (rstn),
      .d    (upd_tgl_reg),
      .q    (tgl_s)
   );

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         tgl_d_reg <= 1'b0;
      else if (ce)
         tgl_d_reg <= tgl_s;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         init_reg <= 1'b1;
      else if (ce)
         init_reg <= 1'b0;
   end

   // Reset release starts the power-up settle; later ones follow each write
   assign settle_start = ce && (init_reg || (tgl_s ^ tgl_d_reg));
   assign settle_data  = init_reg ? iwrs_pkg::WIPER_RESET : wiper_position_reg;

   iwrs_settle u_settle (
      .clk     (core_clk),
      .rstn    (rstn),
      .ce      (ce),
      .start   (settle_start),
      .data_in (settle_data),
      .tap     (wiper_tap),
      .ready   (wiper_ready),
      .done    (wiper_moved)
   );

   // Checks
   sequence s_byte_taken;
      ce_s && (state_reg == iwrs_pkg::ST_ACK) && fall && !ack_on_reg && !start_ev && !stop_ev;
   endsequence

   sequence s_ack_held;
      sda_oe [*1];
   endsequence

   chk_idle_quiet: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (state_reg == iwrs_pkg::ST_IDLE) |-> !sda_oe)
      else $error("sda driven while idle");

   chk_start_seen: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (ce_s && start_ev) |=> (state_reg == iwrs_pkg::ST_ADDR) && !sda_oe && (cnt_reg == 3'h0))
      else $error("start not decoded");

   chk_stop_seen: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (ce_s && stop_ev) |=> (state_reg == iwrs_pkg::ST_IDLE) && !sda_oe)
      else $error("stop not decoded");

   chk_ack_ninth: assert property (
      @(posedge link_clk) disable iff (!rstn)
      s_byte_taken |=> s_ack_held)
      else $error("acknowledge not driven");

   chk_wiper_load: assert property (
      @(posedge link_clk) disable iff (!rstn)
      wr_ev |=> (wiper_position_reg == $past(byte_in[6:0])) && (upd_tgl_reg != $past(upd_tgl_reg)))
      else $error("wiper register not loaded");

   chk_bad_index: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (ce_s && !start_ev && !stop_ev && (state_reg == iwrs_pkg::ST_REG) && byte_end &&
       (byte_in != iwrs_pkg::WIPER_ADDR)) |=> (state_reg == iwrs_pkg::ST_WAIT) && !sda_oe)
      else $error("bad index acknowledged");

   chk_read_nack: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (ce_s && !start_ev && !stop_ev && (state_reg == iwrs_pkg::ST_TX_ACK) && rise && sda_s)
      |=> (state_reg == iwrs_pkg::ST_WAIT) && !sda_oe)
      else $error("read continued after no acknowledge");

   chk_read_msb: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (ce_s && !start_ev && !stop_ev && ack_exit && (after_reg == iwrs_pkg::ST_TX)) |=> sda_oe)
      else $error("read byte top bit not zero");

   chk_id_match: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (ce_s && !start_ev && !stop_ev && (state_reg == iwrs_pkg::ST_ADDR) && byte_end && !addr_hit)
      |=> (state_reg == iwrs_pkg::ST_IDLE) [*2])
      else $error("foreign address answered");

endmodule : iwrs_top

// ### iwrs_master.sv
// Purpose: Behavioural bus master for the wiper register slave
// Assumes: sda has a pull-up; the device pulls low through sda_oe
// Notes:   A 60 ns quarter bit keeps each scl phase far above 4 link_clk
`timescale 1ns/1ps
module iwrs_master (
   // Bus
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   localparam int Q = 60;

   initial
   begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // Also serves as repeated start
   task automatic start_c;
      sda_low = 1'b0;
      #Q scl  = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl  = 1'b0;
      #Q;
   endtask : start_c

   task automatic stop_c;
      sda_low = 1'b1;
      #Q scl  = 1'b1;
      #Q sda_low = 1'b0;
      #(4*Q);
   endtask : stop_c

   // Data changes only while scl is low
   task automatic bit_out(input logic b);
      sda_low = !b;
      #Q scl  = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
   endtask : bit_out

   task automatic bit_in(output logic v);
      sda_low = 1'b0;
      #Q scl  = 1'b1;
      #Q v    = sda;
      #Q scl  = 1'b0;
      #Q;
   endtask : bit_in

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--)
         bit_out(b[i]);
      bit_in(v);
      ack = !v;
   endtask : wr_byte

   // Master acknowledges only when more bytes are wanted
   task automatic rd_byte(input logic more, output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         bit_in(b[i]);
      bit_out(!more);
   endtask : rd_byte
endmodule : iwrs_master

// ### tb.sv
// Purpose: Self-checking bench for the wiper register slave
// Assumes: Bus master model drives scl and pulls sda
// Notes:   Settle time is measured from the device ack of the data byte
`timescale 1ns/1ps
module tb;
   localparam logic [6:0] ID = 7'h2a; // Arbitrary value

   logic                         core_clk;
   logic                         link_clk;
   logic                         rstn;
   logic                         ce;
   logic                         scl;
   logic                         m_low;
   logic                         sda_out;
   logic                         sda_oe;
   logic [iwrs_pkg::WIPER_W-1:0] wiper_tap;
   logic                         wiper_ready;
   logic                         wiper_moved;
   wire                          sda = (sda_oe ? sda_out : 1'b1) && !m_low;
   int                           failures;
   int                           checks;
   int                           moves;
   realtime                      t_ack;

   iwrs_top #(.DEV_ID(ID)) u_iwrs_top (
      .core_clk(core_clk), .rstn(rstn), .ce(ce), .link_clk(link_clk), .scl(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .wiper_tap(wiper_tap), .wiper_ready(wiper_ready),
      .wiper_moved(wiper_moved));

   iwrs_master u_iwrs_master (.scl(scl), .sda_low(m_low), .sda(sda));

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;
   initial
   begin
      link_clk = 1'b0;
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   always @(posedge sda_oe) t_ack = $realtime;
   always @(negedge core_clk) if (wiper_moved === 1'b1) moves++;

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("Checks %0d, failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   task automatic wr_reg(input logic [6:0] id, input logic [7:0] idx, input logic [7:0] d,
                         output logic [2:0] acks);
      u_iwrs_master.start_c();
      u_iwrs_master.wr_byte({id, 1'b0}, acks[2]);
      u_iwrs_master.wr_byte(idx, acks[1]);
      u_iwrs_master.wr_byte(d, acks[0]);
      u_iwrs_master.stop_c();
   endtask : wr_reg

   // A master ack asks for the same byte once more
   task automatic rd_expect(input logic [6:0] exp, input logic more);
      logic [2:0] a;
      logic [7:0] b;
      u_iwrs_master.start_c();
      u_iwrs_master.wr_byte({ID, 1'b0}, a[2]);
      u_iwrs_master.wr_byte(8'h00, a[1]);
      u_iwrs_master.start_c();
      u_iwrs_master.wr_byte({ID, 1'b1}, a[0]);
      check("read acks", {5'h00, a}, 8'h07);
      u_iwrs_master.rd_byte(more, b);
      check("read byte", b, {1'b0, exp});
      if (more)
      begin
         u_iwrs_master.rd_byte(1'b0, b);
         check("second read byte", b, {1'b0, exp});
      end
      u_iwrs_master.stop_c();
      check("released after read", {7'h00, sda_oe}, 8'h00);
   endtask : rd_expect

   task automatic t_powerup;
      int n;
      check("tap in reset", {1'b0, wiper_tap}, 8'h40);
      check("oe in reset", {7'h00, sda_oe}, 8'h00);
      @(negedge core_clk) rstn = 1'b1;
      n = 0;
      while (wiper_ready !== 1'b1 && n < 200)
      begin
         @(negedge core_clk);
         n++;
      end
      check("power settle in window", {7'h00, n >= 50 && n <= 100}, 8'h01);
      check("ready before first access", {7'h00, n <= iwrs_pkg::POWERUP_MAX_NS / iwrs_pkg::CORE_PERIOD_NS}, 8'h01);
      check("tap after power", {1'b0, wiper_tap}, 8'h40);
      rd_expect(7'h40, 1'b0);
      $display("Test powerup done");
   endtask : t_powerup

   task automatic t_write;
      logic [7:0] vals [2] = '{8'hd5, 8'h80};
      logic [2:0] a;
      realtime    dt;
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(ID, 8'h00, vals[k], a);
         check("write acks", {5'h00, a}, 8'h07);
         dt = 1.0e9;
         for (int n = 0; n < 300; n++)
         begin
            @(negedge core_clk);
            if (wiper_moved === 1'b1)
            begin
               dt = $realtime - t_ack;
               break;
            end
         end
         check("settle in window", {7'h00, dt >= 5000 && dt <= 10000}, 8'h01);
         check("tap after write", {1'b0, wiper_tap}, {1'b0, vals[k][6:0]});
         rd_expect(vals[k][6:0], k == 0);
      end
      $display("Test write done");
   endtask : t_write

   task automatic t_refused;
      logic [2:0] a;
      logic       ack;
      int         m;
      m = moves;
      wr_reg(ID ^ 7'h01, 8'h00, 8'h11, a);
      check("foreign id acks", {5'h00, a}, 8'h00);
      wr_reg(ID, 8'h01, 8'h22, a);
      check("bad index acks", {5'h00, a}, 8'h04);
      u_iwrs_master.scl = 1'b0;
      #60;
      u_iwrs_master.wr_byte({ID, 1'b0}, ack);
      check("no start ack", {7'h00, ack}, 8'h00);
      u_iwrs_master.stop_c();
      repeat (120) @(negedge core_clk);
      check("no move", 8'(moves - m), 8'h00);
      rd_expect(7'h00, 1'b0);
      $display("Test refused done");
   endtask : t_refused

   initial
   begin
      rstn     = 1'b0;
      ce       = 1'b1;
      failures = 0;
      checks   = 0;
      moves    = 0;
      t_ack    = 0;
      repeat (4) @(negedge core_clk);
      t_powerup();
      t_write();
      t_refused();
      stop_test();
   end

   initial
   begin
      #300us;
      failures++;
      stop_test();
   end
endmodule : tb
